// ==== hdl/ext_bank_pkg.sv ====
// Constants for the banked extended register decode of one serial channel
`default_nettype none
package ext_bank_pkg;
	localparam int          DATA_W          = 8;
	localparam int          ADDR_W          = 3;
	localparam int          RX_DEPTH        = 16;
	localparam int          RX_PTR_W        = 4;
	// Offsets within the channel
	localparam logic [2:0]  OFS_DATA        = 3'h0;
	localparam logic [2:0]  OFS_DIV_HIGH    = 3'h1;
	localparam logic [2:0]  OFS_FUNC        = 3'h2;
	localparam logic [2:0]  OFS_LINE_CTRL   = 3'h3;
	localparam logic [2:0]  OFS_RESUME_ONE  = 3'h4;
	localparam logic [2:0]  OFS_RESUME_TWO  = 3'h5;
	localparam logic [2:0]  OFS_PAUSE_ONE   = 3'h6;
	localparam logic [2:0]  OFS_PAUSE_TWO   = 3'h7;
	// Magic line-control value opening the enhanced bank
	localparam logic [7:0]  ENH_BANK_KEY    = 8'h_BF;
	localparam int          LC_DIV_BIT      = 7;
	// Alternate-function fields
	localparam int          AF_DUAL_WR      = 0;
	localparam int          AF_BAUD_SEL     = 1;
	localparam int          AF_RXRDY_SEL    = 2;
	localparam logic [7:0]  AF_WRITE_MASK   = 8'h_07;
	// Enhanced-feature fields
	localparam int          EF_AUTO_CTS     = 7;
	localparam int          EF_AUTO_RTS     = 6;
	localparam int          EF_SPECIAL_CHAR = 5;
	localparam int          EF_ENHANCED_EN  = 4;
	localparam int          EF_SWFC_HI      = 3;
	// Revision register fields; values arbitrary
	localparam logic [3:0]  REV_DEVICE_ID   = 4'h_5;
	localparam logic [3:0]  REV_NUMBER      = 4'h_1;
	// Reset values
	localparam logic [7:0]  RST_ZERO        = 8'h_00;
	localparam logic [7:0]  DIV_RST_VAL     = 8'h_00;
endpackage : ext_bank_pkg
`default_nettype wire

// ==== hdl/rx_byte_store.sv ====
// Receive shift register feeding a flip-flop receive queue
`default_nettype none
module rx_byte_store
	import ext_bank_pkg::*;
(
	input  wire logic              i_ref_clk,  // System clock
	input  wire logic              i_rst_n,    // Sync reset, active low
	input  wire logic              i_bit_vld,  // Serial bit strobe
	input  wire logic              i_bit,      // Serial bit value
	input  wire logic              i_flush,    // Empty the queue
	input  wire logic              i_pop,      // Host takes one byte
	output logic [DATA_W-1:0]      o_head,     // Oldest byte
	output logic                   o_has_data, // Queue not empty
	output logic                   o_overrun   // Byte dropped, sticky
);
	logic [DATA_W-1:0]   shift_reg;
	logic [DATA_W-1:0]   shift_next;
	logic [2:0]          bitcnt_reg;
	logic [DATA_W-1:0]   mem_reg [RX_DEPTH];
	logic [RX_PTR_W-1:0] wr_reg;
	logic [RX_PTR_W-1:0] rd_reg;
	logic [RX_PTR_W:0]   cnt_reg;
	logic                byte_done;
	logic                full;
	logic                push;
	logic                pop_ok;

	// Eight bits assemble into one byte, LSB first
	assign shift_next = {i_bit, shift_reg[DATA_W-1:1]};
	assign byte_done  = i_bit_vld && (bitcnt_reg == 3'h7);
	assign full       = cnt_reg == (RX_PTR_W+1)'(RX_DEPTH);
	assign push       = byte_done && !full;
	assign pop_ok     = i_pop && (cnt_reg != '0);
	assign o_head     = mem_reg[rd_reg];
	assign o_has_data = cnt_reg != '0;

	// Shift register keeps its content over reset like the data path
	always_ff @(posedge i_ref_clk)
	begin
		if (i_bit_vld)
			shift_reg <= shift_next;
		if (push)
			mem_reg[wr_reg] <= shift_next;
	end

	// Pointers and count; a full queue drops the new byte
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n || i_flush)
		begin
			bitcnt_reg <= '0;
			wr_reg     <= '0;
			rd_reg     <= '0;
			cnt_reg    <= '0;
			o_overrun  <= 1'b0;
		end
		else
		begin
			if (i_bit_vld)
				bitcnt_reg <= bitcnt_reg + 3'h1;
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop_ok)
				rd_reg <= rd_reg + 1'b1;
			cnt_reg <= cnt_reg + (RX_PTR_W+1)'(push) - (RX_PTR_W+1)'(pop_ok);
			if (byte_done && full)
				o_overrun <= 1'b1;
		end
	end
endmodule : rx_byte_store
`default_nettype wire

// ==== hdl/uart_extended_register_bank.sv ====
// Banked register decode for one channel: divisor and enhanced banks
`default_nettype none

module uart_extended_register_bank
	import ext_bank_pkg::*;
(
	input  wire logic                     i_ref_clk,     // System clock
	input  wire logic                     i_rst_n,       // Sync reset
	input  wire logic                     i_cs_n,        // Channel select
	input  wire logic                     i_rd_n,        // Read strobe
	input  wire logic                     i_wr_n,        // Write strobe
	input  wire logic [ext_bank_pkg::ADDR_W-1:0] i_addr, // Offset A2..A0
	input  wire logic [ext_bank_pkg::DATA_W-1:0] i_wdata, // Write data
	input  wire logic [ext_bank_pkg::DATA_W-1:0] i_ier,  // Raw int enables
	input  wire logic                     i_rx_bit_vld,  // Serial bit strobe
	input  wire logic                     i_rx_bit,      // Serial bit value
	input  wire logic                     i_rx_flush,    // Receive reset
	output logic [ext_bank_pkg::DATA_W-1:0] o_rdata,     // Read data
	output logic [ext_bank_pkg::DATA_W-1:0] o_line_control, // Line control
	output logic [15:0]                   o_divisor,     // Baud divisor
	output logic [ext_bank_pkg::DATA_W-1:0] o_tx_data,   // Transmit byte
	output logic                          o_tx_load,     // Transmit strobe
	output logic                          o_dual_write,  // Dual write enable
	output logic                          o_baud_sel,    // Baud pin select
	output logic                          o_rxrdy_sel,   // Rx-ready select
	output logic                          o_auto_cts,    // Auto CTS enable
	output logic                          o_auto_rts,    // Auto RTS enable
	output logic                          o_special_char,// Special char select
	output logic                          o_enhanced_en, // Enhanced unlock
	output logic [3:0]                    o_swfc_mode,   // SW flow config
	output logic [ext_bank_pkg::DATA_W-1:0] o_ier_eff,   // Gated enables
	output logic [ext_bank_pkg::DATA_W-1:0] o_resume_one,// First resume char
	output logic [ext_bank_pkg::DATA_W-1:0] o_resume_two,// Second resume char
	output logic [ext_bank_pkg::DATA_W-1:0] o_pause_one, // First pause char
	output logic [ext_bank_pkg::DATA_W-1:0] o_pause_two, // Second pause char
	output logic                          o_rx_ready,    // Receive data ready
	output logic                          o_rx_overrun   // Receive overrun
);
	import ext_bank_pkg::*;

	logic [7:0] line_control_reg;
	logic [7:0] divisor_low_byte_reg;
	logic [7:0] divisor_high_byte_reg;
	logic [7:0] alternate_function_select_reg;
	logic [7:0] enhanced_feature_control_reg;
	logic [7:0] flow_resume_char_one_reg;
	logic [7:0] flow_resume_char_two_reg;
	logic [7:0] flow_pause_char_one_reg;
	logic [7:0] flow_pause_char_two_reg;
	logic [7:0] tx_data_reg;
	logic       tx_load_reg;
	logic       rd_prev_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic [7:0] device_revision;
	logic [7:0] rx_head;
	logic [7:0] line_control_next;
	logic [7:0] divisor_low_byte_next;
	logic [7:0] divisor_high_byte_next;
	logic [7:0] alternate_function_select_next;
	logic [7:0] enhanced_feature_control_next;
	logic [7:0] flow_resume_char_one_next;
	logic [7:0] flow_resume_char_two_next;
	logic [7:0] flow_pause_char_one_next;
	logic [7:0] flow_pause_char_two_next;
	logic [7:0] tx_data_next;

	// Bus strobes; a normal-bank read of offset 0 pops the queue once, on its leading edge
	wire        wr_en    = !i_cs_n && !i_wr_n;
	wire        rd_en    = !i_cs_n && !i_rd_n;
	wire        rd_start = rd_en && !rd_prev_reg;

	// Bank selection from the line-control value
	wire        key_bank = line_control_reg == ENH_BANK_KEY;
	wire        div_bank = line_control_reg[LC_DIV_BIT] && !key_bank;
	wire        norm_bank = !line_control_reg[LC_DIV_BIT];
	wire        div_zero = (divisor_low_byte_reg == RST_ZERO) &&
	                       (divisor_high_byte_reg == RST_ZERO);

	// Per-register write decodes
	wire wr_lc     = wr_en && (i_addr == OFS_LINE_CTRL);
	wire wr_dll    = wr_en && div_bank && (i_addr == OFS_DATA);
	wire wr_dlm    = wr_en && div_bank && (i_addr == OFS_DIV_HIGH);
	wire wr_af     = wr_en && div_bank && (i_addr == OFS_FUNC);
	wire wr_ef     = wr_en && key_bank && (i_addr == OFS_FUNC);
	wire wr_flow_resume_char_one   = wr_en && key_bank && (i_addr == OFS_RESUME_ONE);
	wire wr_flow_resume_char_two   = wr_en && key_bank && (i_addr == OFS_RESUME_TWO);
	wire wr_flow_pause_char_one  = wr_en && key_bank && (i_addr == OFS_PAUSE_ONE);
	wire wr_flow_pause_char_two  = wr_en && key_bank && (i_addr == OFS_PAUSE_TWO);
	wire wr_thr    = wr_en && norm_bank && (i_addr == OFS_DATA);
	wire rx_pop    = rd_start && norm_bank && (i_addr == OFS_DATA);

	// Next values: a decoded write replaces the byte, otherwise it holds
	assign line_control_next =
		wr_lc ? i_wdata : line_control_reg;
	assign divisor_low_byte_next =
		wr_dll ? i_wdata : divisor_low_byte_reg;
	assign divisor_high_byte_next =
		wr_dlm ? i_wdata : divisor_high_byte_reg;
	// Reserved function bits never store, so they cannot read back set
	assign alternate_function_select_next = wr_af ?
		(i_wdata & AF_WRITE_MASK) : alternate_function_select_reg;
	assign enhanced_feature_control_next =
		wr_ef ? i_wdata : enhanced_feature_control_reg;
	// Flow-control characters only move while the key bank is open
	assign flow_resume_char_one_next =
		wr_flow_resume_char_one ? i_wdata : flow_resume_char_one_reg;
	assign flow_resume_char_two_next =
		wr_flow_resume_char_two ? i_wdata : flow_resume_char_two_reg;
	assign flow_pause_char_one_next =
		wr_flow_pause_char_one ? i_wdata : flow_pause_char_one_reg;
	assign flow_pause_char_two_next =
		wr_flow_pause_char_two ? i_wdata : flow_pause_char_two_reg;
	assign tx_data_next =
		wr_thr ? i_wdata : tx_data_reg;

	// Revision: id in the upper nibble, revision in the lower
	assign device_revision = {REV_DEVICE_ID, REV_NUMBER};

	// Read mux; a zero divisor exposes the revision at offset 0 in the divisor bank
	always_comb
	begin
		rdata_next = RST_ZERO;
		unique case (i_addr)
			OFS_DATA:
				if (norm_bank)
					rdata_next = rx_head;
				else if (div_bank && div_zero)
					rdata_next = device_revision;
				else if (div_bank)
					rdata_next = divisor_low_byte_reg;
			OFS_DIV_HIGH:
				if (div_bank)
					rdata_next = divisor_high_byte_reg;
			OFS_FUNC:
				if (key_bank)
					rdata_next = enhanced_feature_control_reg;
				else if (div_bank)
					rdata_next = alternate_function_select_reg
					             & AF_WRITE_MASK;
			OFS_LINE_CTRL:
				rdata_next = line_control_reg;
			OFS_RESUME_ONE:
				if (key_bank)
					rdata_next = flow_resume_char_one_reg;
			OFS_RESUME_TWO:
				if (key_bank)
					rdata_next = flow_resume_char_two_reg;
			OFS_PAUSE_ONE:
				if (key_bank)
					rdata_next = flow_pause_char_one_reg;
			OFS_PAUSE_TWO:
				if (key_bank)
					rdata_next = flow_pause_char_two_reg;
		endcase
	end

	// Line control picks the bank seen at every other offset
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			line_control_reg <= RST_ZERO;
		else
			line_control_reg <= line_control_next;
	end

	// Divisor low byte: undefined at reset, held at zero here
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			divisor_low_byte_reg <= DIV_RST_VAL;
		else
			divisor_low_byte_reg <= divisor_low_byte_next;
	end

	// Divisor high byte; zero at reset leaves the revision readable
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			divisor_high_byte_reg <= DIV_RST_VAL;
		else
			divisor_high_byte_reg <= divisor_high_byte_next;
	end

	// Alternate-function select
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			alternate_function_select_reg <= RST_ZERO;
		else
			alternate_function_select_reg <= alternate_function_select_next;
	end

	// Enhanced-feature control
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			enhanced_feature_control_reg <= RST_ZERO;
		else
			enhanced_feature_control_reg <= enhanced_feature_control_next;
	end

	// First resume character
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			flow_resume_char_one_reg <= RST_ZERO;
		else
			flow_resume_char_one_reg <= flow_resume_char_one_next;
	end

	// Second resume character
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			flow_resume_char_two_reg <= RST_ZERO;
		else
			flow_resume_char_two_reg <= flow_resume_char_two_next;
	end

	// First pause character
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			flow_pause_char_one_reg <= RST_ZERO;
		else
			flow_pause_char_one_reg <= flow_pause_char_one_next;
	end

	// Second pause character
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			flow_pause_char_two_reg <= RST_ZERO;
		else
			flow_pause_char_two_reg <= flow_pause_char_two_next;
	end

	// Transmit byte stays until the next normal-bank write to offset 0
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			tx_data_reg <= RST_ZERO;
		else
			tx_data_reg <= tx_data_next;
	end

	// Transmit strobe, read data and strobe edge tracking
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			tx_load_reg <= 1'b0;
			rd_prev_reg <= 1'b0;
			rdata_reg   <= RST_ZERO;
		end
		else
		begin
			tx_load_reg <= wr_thr;
			rd_prev_reg <= rd_en;
			rdata_reg   <= rdata_next;
		end
	end

	// Receive queue behind the receive buffer
	rx_byte_store u_rx_store (
		.i_ref_clk  (i_ref_clk),
		.i_rst_n    (i_rst_n),
		.i_bit_vld  (i_rx_bit_vld),
		.i_bit      (i_rx_bit),
		.i_flush    (i_rx_flush),
		.i_pop      (rx_pop),
		.o_head     (rx_head),
		.o_has_data (o_rx_ready),
		.o_overrun  (o_rx_overrun)
	);

	// Field outputs
	assign o_rdata        = rdata_reg;
	assign o_line_control = line_control_reg;
	assign o_divisor      = {divisor_high_byte_reg, divisor_low_byte_reg};
	assign o_tx_data      = tx_data_reg;
	assign o_tx_load      = tx_load_reg;
	assign o_dual_write   = alternate_function_select_reg[AF_DUAL_WR];
	assign o_baud_sel     = alternate_function_select_reg[AF_BAUD_SEL];
	assign o_rxrdy_sel    = alternate_function_select_reg[AF_RXRDY_SEL];
	assign o_auto_cts     = enhanced_feature_control_reg[EF_AUTO_CTS];
	assign o_auto_rts     = enhanced_feature_control_reg[EF_AUTO_RTS];
	assign o_special_char = enhanced_feature_control_reg[EF_SPECIAL_CHAR];
	assign o_enhanced_en  = enhanced_feature_control_reg[EF_ENHANCED_EN];
	assign o_swfc_mode    = enhanced_feature_control_reg[EF_SWFC_HI:0];
	assign o_resume_one   = flow_resume_char_one_reg;
	assign o_resume_two   = flow_resume_char_two_reg;
	assign o_pause_one    = flow_pause_char_one_reg;
	assign o_pause_two    = flow_pause_char_two_reg;

	// Upper enables are masked unless the enhanced unlock is set
	assign o_ier_eff = {i_ier[7:4] & {4{o_enhanced_en}}, i_ier[3:0]};
endmodule : uart_extended_register_bank
`default_nettype wire

// ==== tb/uart_extended_register_bank_props.sv ====
// Port-level properties of the banked extended register decode
`default_nettype none
module uart_extended_register_bank_props
(
	input  wire logic                              i_ref_clk,      // Clock
	input  wire logic                              i_rst_n,        // Reset
	input  wire logic                              i_cs_n,         // Select
	input  wire logic                              i_wr_n,         // Write
	input  wire logic [ext_bank_pkg::ADDR_W-1:0]   i_addr,         // Offset
	input  wire logic [ext_bank_pkg::DATA_W-1:0]   i_wdata,        // Data
	input  wire logic [ext_bank_pkg::DATA_W-1:0]   i_ier,          // Enables
	input  wire logic [ext_bank_pkg::DATA_W-1:0]   o_rdata,        // Read
	input  wire logic [ext_bank_pkg::DATA_W-1:0]   o_line_control, // Line
	input  wire logic [15:0]                       o_divisor,      // Divisor
	input  wire logic [ext_bank_pkg::DATA_W-1:0]   o_tx_data,      // Tx byte
	input  wire logic                              o_tx_load,      // Tx load
	input  wire logic                              o_dual_write,   // Alt 0
	input  wire logic                              o_baud_sel,     // Alt 1
	input  wire logic                              o_rxrdy_sel,    // Alt 2
	input  wire logic                              o_auto_cts,     // Enh 7
	input  wire logic                              o_auto_rts,     // Enh 6
	input  wire logic                              o_special_char, // Enh 5
	input  wire logic                              o_enhanced_en,  // Enh 4
	input  wire logic [3:0]                        o_swfc_mode,    // Enh 3:0
	input  wire logic [ext_bank_pkg::DATA_W-1:0]   o_ier_eff,      // Gated
	input  wire logic [ext_bank_pkg::DATA_W-1:0]   o_resume_one,   // Resume
	input  wire logic [ext_bank_pkg::DATA_W-1:0]   o_pause_one     // Pause
);
	timeunit 1ns;
	timeprecision 1ps;
	import ext_bank_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Bank decode mirrored from line control; writes are taken every edge
	wire logic wr_now   = !i_cs_n && !i_wr_n;
	wire logic key_bank = o_line_control == ENH_BANK_KEY;
	wire logic div_bank = o_line_control[LC_DIV_BIT] && !key_bank;
	wire logic thr_wr   = wr_now && i_addr == OFS_DATA && !o_line_control[7];
	wire logic efr_wr   = key_bank && wr_now && i_addr == OFS_FUNC;

	a_line_ctrl_write: assert property (wr_now && i_addr == OFS_LINE_CTRL
		|=> o_line_control == $past(i_wdata)) else $error("line control lost");
	a_tx_load_pulse: assert property (thr_wr
		|=> o_tx_load && o_tx_data == $past(i_wdata)) else $error("tx load bad");
	a_tx_load_cause: assert property (o_tx_load |-> $past(thr_wr))
		else $error("tx load without write");
	a_div_low_write: assert property (div_bank && wr_now
		&& i_addr == OFS_DATA |=> o_divisor[7:0] == $past(i_wdata))
		else $error("div low");
	a_div_high_write: assert property (div_bank && wr_now
		&& i_addr == OFS_DIV_HIGH |=> o_divisor[15:8] == $past(i_wdata))
		else $error("div high");
	a_func_bits_write: assert property (div_bank && wr_now
		&& i_addr == OFS_FUNC |=> {5'h_00, o_rxrdy_sel, o_baud_sel,
		o_dual_write} == ($past(i_wdata) & AF_WRITE_MASK)) else $error("alt");
	a_enh_bits_write: assert property (efr_wr |=> {o_auto_cts, o_auto_rts,
		o_special_char, o_enhanced_en, o_swfc_mode} == $past(i_wdata))
		else $error("enhanced");
	a_resume_write: assert property (key_bank && wr_now
		&& i_addr == OFS_RESUME_ONE |=> o_resume_one == $past(i_wdata))
		else $error("resume");
	a_pause_write: assert property (key_bank && wr_now
		&& i_addr == OFS_PAUSE_ONE |=> o_pause_one == $past(i_wdata))
		else $error("pause");
	a_rev_read: assert property (div_bank && i_addr == OFS_DATA
		&& o_divisor == 16'h_0000 |=> o_rdata == {REV_DEVICE_ID, REV_NUMBER})
		else $error("revision");
	a_func_rsvd_read: assert property (div_bank && i_addr == OFS_FUNC
		|=> o_rdata[7:3] == 5'h_00) else $error("reserved bits");
	a_ier_gate: assert property (o_ier_eff[3:0] == i_ier[3:0]
		&& o_ier_eff[7:4] == (i_ier[7:4] & {4{o_enhanced_en}}))
		else $error("enable gate");
	// Main scenarios reached
	c_thr_write: cover property (thr_wr);
	c_efr_write: cover property (efr_wr);
	c_rev_read: cover property (div_bank && o_divisor == 16'h_0000);
endmodule : uart_extended_register_bank_props

bind uart_extended_register_bank uart_extended_register_bank_props u_props
(
	.i_ref_clk, .i_rst_n, .i_cs_n, .i_wr_n, .i_addr, .i_wdata, .i_ier,
	.o_rdata, .o_line_control, .o_divisor, .o_tx_data, .o_tx_load,
	.o_dual_write, .o_baud_sel, .o_rxrdy_sel, .o_auto_cts, .o_auto_rts,
	.o_special_char, .o_enhanced_en, .o_swfc_mode, .o_ier_eff,
	.o_resume_one, .o_pause_one
);
`default_nettype wire

// ==== tb/host_bus_model.sv ====
// Host processor model driving the parallel register bus
`default_nettype none
module host_bus_model
(
	input  wire logic                            i_ref_clk, // Clock
	input  wire logic [ext_bank_pkg::DATA_W-1:0] i_rdata,   // Read data
	output logic                                 o_cs_n,    // Select
	output logic                                 o_rd_n,    // Read
	output logic                                 o_wr_n,    // Write
	output logic [ext_bank_pkg::ADDR_W-1:0]      o_addr,    // Offset
	output logic [ext_bank_pkg::DATA_W-1:0]      o_wdata    // Write data
);
	timeunit 1ns;
	timeprecision 1ps;
	import ext_bank_pkg::*;
	// Idle bus; address and data flip so a stale value never looks held
	task automatic idle;
		o_cs_n  = 1'b1;
		o_rd_n  = 1'b1;
		o_wr_n  = 1'b1;
		o_addr  = ~o_addr;
		o_wdata = ~o_wdata;
	endtask : idle
	initial
	begin
		o_addr  = '0;
		o_wdata = '0;
		idle();
	end
	// One write cycle: a longer strobe would write twice
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(negedge i_ref_clk);
		o_addr  = a;
		o_wdata = v;
		o_cs_n  = 1'b0;
		o_wr_n  = 1'b0;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		idle();
	endtask : wr
	// Read data stands from the edge that takes the address; it is
	// taken at the next falling edge, away from the edge that relaunches it
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(negedge i_ref_clk);
		o_addr = a;
		o_cs_n = 1'b0;
		o_rd_n = 1'b0;
		@(posedge i_ref_clk);
		@(negedge i_ref_clk);
		v = i_rdata;
		idle();
	endtask : rd
endmodule : host_bus_model
`default_nettype wire

// ==== tb/uart_extended_register_bank_test.sv ====
// Self-checking bench for the banked extended register decode
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module uart_extended_register_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ext_bank_pkg::*;
	logic              i_ref_clk = 1'b0, i_rst_n = 1'b0;
	logic              i_cs_n, i_rd_n, i_wr_n, o_tx_load, o_rx_ready;
	logic              i_rx_bit_vld = 1'b0, i_rx_bit = 1'b0, i_rx_flush = 1'b0;
	logic              o_dual_write, o_baud_sel, o_rxrdy_sel, o_auto_cts;
	logic              o_auto_rts, o_special_char, o_enhanced_en, o_rx_overrun;
	logic [ADDR_W-1:0] i_addr;
	logic [DATA_W-1:0] i_wdata, i_ier = 8'h_F5, o_rdata, o_line_control, d;
	logic [DATA_W-1:0] o_tx_data, o_ier_eff, o_resume_one, o_resume_two;
	logic [DATA_W-1:0] o_pause_one, o_pause_two;
	logic [15:0]       o_divisor;
	logic [3:0]        o_swfc_mode;
	int                num_errors = 0, n_tests = 0;

	always #5 i_ref_clk = ~i_ref_clk;
	host_bus_model host (.i_ref_clk, .i_rdata(o_rdata), .o_cs_n(i_cs_n),
		.o_rd_n(i_rd_n), .o_wr_n(i_wr_n), .o_addr(i_addr), .o_wdata(i_wdata));
	uart_extended_register_bank dut (.i_ref_clk, .i_rst_n, .i_cs_n, .i_rd_n,
		.i_wr_n, .i_addr, .i_wdata, .i_ier, .i_rx_bit_vld, .i_rx_bit,
		.i_rx_flush, .o_rdata, .o_line_control, .o_divisor, .o_tx_data,
		.o_tx_load, .o_dual_write, .o_baud_sel, .o_rxrdy_sel, .o_auto_cts,
		.o_auto_rts, .o_special_char, .o_enhanced_en, .o_swfc_mode, .o_ier_eff,
		.o_resume_one, .o_resume_two, .o_pause_one, .o_pause_two, .o_rx_ready,
		.o_rx_overrun);

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : conclude
	// One received byte, LSB first, one strobe every other cycle
	task automatic send_byte(input logic [DATA_W-1:0] b);
		for (int i = 0; i < DATA_W; i++)
		begin
			@(negedge i_ref_clk);
			i_rx_bit_vld = 1'b1;
			i_rx_bit     = b[i];
			@(negedge i_ref_clk);
			i_rx_bit_vld = 1'b0;
		end
	endtask : send_byte
	// Key bank: reset zeros, read-back, fields, upper enable gate
	task automatic t_key;
		host.wr(OFS_LINE_CTRL, ENH_BANK_KEY);
		`CHK(o_line_control, ENH_BANK_KEY)
		for (int a = 2; a < 8; a++)
			if (a != 3)
			begin
				host.rd(a[2:0], d);
				`CHK(d, RST_ZERO)
				host.wr(a[2:0], 8'h_A0 | 8'(a));
				host.rd(a[2:0], d);
				`CHK(d, 8'h_A0 | 8'(a))
			end
		`CHK(o_ier_eff, 8'h_05)
		`CHK({o_resume_one, o_resume_two}, 16'h_A4A5)
		`CHK({o_pause_one, o_pause_two}, 16'h_A6A7)
		host.wr(OFS_FUNC, 8'h_DB);
		`CHK({o_auto_cts, o_auto_rts, o_special_char, o_enhanced_en}, 4'h_D)
		`CHK(o_swfc_mode, 4'h_B)
		`CHK(o_ier_eff, 8'h_F5)
		$display("t_key done");
	endtask : t_key
	// Divisor bank: revision at zero divisor, masked alternate bits
	task automatic t_div;
		host.wr(OFS_LINE_CTRL, 8'h_80);
		host.rd(OFS_DATA, d);
		`CHK(d, {REV_DEVICE_ID, REV_NUMBER})
		host.rd(OFS_FUNC, d);
		`CHK(d, RST_ZERO)
		host.wr(OFS_FUNC, 8'h_FE);
		host.rd(OFS_FUNC, d);
		`CHK(d, 8'h_06)
		`CHK({o_rxrdy_sel, o_baud_sel, o_dual_write}, 3'h_6)
		host.wr(OFS_DATA, 8'h_34);
		host.wr(OFS_DIV_HIGH, 8'h_12);
		host.rd(OFS_DATA, d);
		`CHK(d, 8'h_34)
		host.rd(OFS_DIV_HIGH, d);
		`CHK(d, 8'h_12)
		host.wr(OFS_DATA, 8'h_00);
		host.rd(OFS_DATA, d);
		`CHK(d, 8'h_00)
		host.wr(OFS_RESUME_ONE, 8'h_EE);
		`CHK(o_resume_one, 8'h_A4)
		$display("t_div done");
	endtask : t_div
	// Normal bank: byte in through shift register, out at offset 0,
	// then a full queue drops the next byte and flush clears it all
	task automatic t_rx;
		host.wr(OFS_LINE_CTRL, 8'h_03);
		send_byte(8'h_A5);
		`CHK(o_rx_ready, 1'b1)
		host.rd(OFS_DATA, d);
		`CHK(d, 8'h_A5)
		`CHK(o_rx_ready, 1'b0)
		host.wr(OFS_DATA, 8'h_3C);
		`CHK(o_tx_load, 1'b1)
		`CHK(o_tx_data, 8'h_3C)
		`CHK(o_divisor, 16'h_1200)
		@(negedge i_ref_clk);
		`CHK(o_tx_load, 1'b0)
		for (int k = 0; k < RX_DEPTH; k++)
			send_byte(8'(k));
		`CHK(o_rx_overrun, 1'b0)
		send_byte(8'h_FF);
		`CHK(o_rx_overrun, 1'b1)
		host.rd(OFS_DATA, d);
		`CHK(d, 8'h_00)
		i_rx_flush = 1'b1;
		@(negedge i_ref_clk);
		i_rx_flush = 1'b0;
		`CHK(o_rx_overrun, 1'b0)
		`CHK(o_rx_ready, 1'b0)
		$display("t_rx done");
	endtask : t_rx
	// Hang guard
	initial
	begin
		repeat (5000) @(posedge i_ref_clk);
		num_errors++;
		conclude();
	end
	initial
	begin
		repeat (10) @(negedge i_ref_clk);
		i_rst_n = 1'b1;
		t_key();
		t_div();
		t_rx();
		conclude();
	end
endmodule : uart_extended_register_bank_test
`default_nettype wire
